// file: pkg/dac_regs_pkg.sv
// Shared constants and carrier types of the analog output register bank
package dac_regs_pkg;
  localparam int NUM_CH = 16;
  localparam int ADDR_W = 9;
  // Register offsets (byte addresses) and calibration store size in words
  localparam logic [8:0] RELAY_CTRL_OFS = 9'h01C;
  localparam logic [8:0] CARD_CTRL_OFS = 9'h01E;
  localparam logic [8:0] IMM_VALUE_OFS = 9'h040;
  localparam logic [8:0] TRIG_VALUE_OFS = 9'h060;
  localparam logic [8:0] OFFSET_TRIM_OFS = 9'h080;
  localparam logic [8:0] GAIN_TRIM_OFS = 9'h0A0;
  localparam logic [8:0] NV_BASE_OFS = 9'h100;
  localparam logic [8:0] WINDOW_LO_OFS = 9'h020;
  localparam logic [8:0] WINDOW_HI_OFS = 9'h03E;
  localparam int NV_WORDS = 128;
  // Group selector: byte address bits [8:5] give a 32-byte group
  localparam logic [3:0] GRP_IMM = 4'h2;
  localparam logic [3:0] GRP_TRIG = 4'h3;
  localparam logic [3:0] GRP_OFFSET = 4'h4;
  localparam logic [3:0] GRP_GAIN = 4'h5;
  // Card control field positions
  localparam int PAGE_LSB = 0;
  localparam int PAGE_W = 4;
  localparam int PROG_EN_BIT = 4;
  // Reset values and the eight-channel upper-bit readback mask
  localparam logic [15:0] RELAY_RESET = 16'hFFFF;
  localparam logic [PAGE_W-1:0] PAGE_RESET = 4'h0;
  localparam logic PROG_EN_RESET = 1'b0;
  localparam logic [15:0] MAIN_RESET = 16'h0000;
  localparam logic [11:0] TRIM_RESET = 12'h800;
  localparam logic [15:0] NV_RESET = 16'h0000;
  localparam logic [15:0] UPPER_CH_ONES = 16'hFF00;
  // Relay settle time
  localparam int RELAY_SETTLE_MS = 5;
  localparam int CLK_FREQ_KHZ = 250000;
  localparam int RELAY_SETTLE_CYCLES = RELAY_SETTLE_MS * CLK_FREQ_KHZ;
  localparam int SETTLE_CNT_W = 21;

  // One register access from the backplane controller
  typedef struct packed {
    logic wr;
    logic rd;
    logic wide;
    logic [ADDR_W-1:0] addr;
    logic [15:0] wdata;
  } reg_req_t;

  // Converter codes driven to the analog side
  typedef struct packed {
    logic [NUM_CH-1:0][15:0] main_code;
    logic [NUM_CH-1:0][11:0] offset_code;
    logic [NUM_CH-1:0][11:0] gain_code;
  } dac_codes_t;
endpackage : dac_regs_pkg

// file: rtl/dac_module_register_bank.sv
// Register bank of the 16-channel analog output module
`timescale 1ns/1ps

// Contract
// - Relay bit 1 opens, 0 closes
// - Relay write completes now; relays settle later
// - Relay read returns programmed state
// - Eight-channel build reads ones in upper bits
// - Nonvolatile changes only with program-enable set
// - Nonvolatile memory spans offsets 100 to 1FE
// - Program voltage also needs calibrate jumper; nv_program_voltage_enable follows program-enable alone
// - Page select maps group into 20-3E
// - Page values map to listed register groups
// - Each page step moves window 32 bytes
// - Pages 8-F expose flash calibration memory
// - Immediate values at 40-5E drive output now
// - Main codes are 16-bit two's complement
// - Triggered values at 60-7E wait for trigger
// - All pending values update together
// - Offset trims at 80-9E, 12-bit, immediate
// - Triggered write sets trigger pending
// - Immediate write clears trigger pending
module dac_module_register_bank #(
  parameter int RELAY_SETTLE = dac_regs_pkg::RELAY_SETTLE_CYCLES // Relay settle cycles
) (
  input wire logic ref_clk, // 250 MHz clock
  input wire logic rst, // Synchronous reset, active high
  input wire dac_regs_pkg::reg_req_t req, // Register access request
  output logic [15:0] rd_data, // Read data, registered
  output logic rd_valid, // Read data valid pulse
  input wire logic trigger_event, // Trigger pulse from trigger logic
  input wire logic eight_channel_pin, // Build strap, high for eight channels
  input wire logic cal_jumper_pin, // Board jumper, high in calibrate position
  output logic [15:0] channel_output_switch, // Relay drive, 1 opens
  output logic relay_busy, // Relays still moving
  output logic [15:0] trigger_pending, // Per-channel trigger pending
  output logic nv_program_voltage_enable, // Programming voltage switch
  output dac_regs_pkg::dac_codes_t dac_codes // Converter codes
);
  import dac_regs_pkg::*;

  // Synchronised straps
  logic [1:0] eight_sync_reg;
  logic [1:0] cal_sync_reg;

  // Programmed register state
  logic [15:0] relay_reg;
  logic [PAGE_W-1:0] page_reg;
  logic prog_en_reg;
  logic [NUM_CH-1:0][15:0] main_reg;
  logic [NUM_CH-1:0][15:0] hold_reg;
  logic [NUM_CH-1:0][11:0] offset_reg;
  logic [NUM_CH-1:0][11:0] gain_reg;
  logic [15:0] pending_reg;
  logic [15:0] pending_next;
  logic [SETTLE_CNT_W-1:0] settle_reg;

  // Calibration store, 128 words from offset 100
  logic [15:0] nv_mem [NV_WORDS];

  // Address path
  logic [ADDR_W-1:0] eff_addr;
  logic addr_ok;
  logic [3:0] grp;
  logic [3:0] ch;
  logic nv_hit;
  logic nv_write_ok;
  logic narrow_too_high;
  logic narrow_in_window;
  logic relay_sel;
  logic card_sel;

  // Write strobes per register group
  logic relay_wr;
  logic card_wr;
  logic imm_wr;
  logic trig_wr;
  logic offset_wr;
  logic gain_wr;
  logic nv_wr;

  // Per-channel strobes and trigger copy mask
  logic [NUM_CH-1:0] imm_wr_ch;
  logic [NUM_CH-1:0] trig_wr_ch;
  logic [NUM_CH-1:0] offset_wr_ch;
  logic [NUM_CH-1:0] gain_wr_ch;
  logic [NUM_CH-1:0] copy_ch;

  // Read path
  logic [15:0] rd_next;
  logic [15:0] relay_rd_value;
  logic [15:0] card_rd_value;

  // Build strap comes from a pin, so two flops before use
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      eight_sync_reg <= 2'b00;
    end else begin
      eight_sync_reg <= {eight_sync_reg[0], eight_channel_pin};
    end
  end

  // Calibrate jumper, synchronised the same way
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cal_sync_reg <= 2'b00;
    end else begin
      cal_sync_reg <= {cal_sync_reg[0], cal_jumper_pin};
    end
  end

  // Narrow space ends at 3F; anything above it is ignored
  assign narrow_too_high = !req.wide && (req.addr > WINDOW_HI_OFS + 9'h001);
  assign narrow_in_window = !req.wide && !narrow_too_high && (req.addr >= WINDOW_LO_OFS);
  assign addr_ok = !narrow_too_high;

  // Narrow accesses to 20-3E land in the paged group
  always_comb begin
    eff_addr = req.addr;
    if (narrow_in_window) begin
      eff_addr = {page_reg, req.addr[4:0]};
    end
  end

  // Group and channel fields of the resolved address
  assign grp = eff_addr[8:5];
  assign ch = eff_addr[4:1];

  // Calibration store hit and write permission
  assign nv_hit = addr_ok && (eff_addr >= NV_BASE_OFS);
  assign nv_write_ok = prog_en_reg && cal_sync_reg[1];

  // Selects shared by the write and read paths
  assign relay_sel = addr_ok && (eff_addr[8:1] == RELAY_CTRL_OFS[8:1]);
  assign card_sel = addr_ok && (eff_addr[8:1] == CARD_CTRL_OFS[8:1]);

  // Write strobes; every write finishes in the cycle it is taken
  assign relay_wr = req.wr && relay_sel;
  assign card_wr = req.wr && card_sel;
  assign imm_wr = req.wr && addr_ok && (grp == GRP_IMM);
  assign trig_wr = req.wr && addr_ok && (grp == GRP_TRIG);
  assign offset_wr = req.wr && addr_ok && (grp == GRP_OFFSET);
  assign gain_wr = req.wr && addr_ok && (grp == GRP_GAIN);
  assign nv_wr = req.wr && nv_hit && nv_write_ok;

  // One channel at most matches per access, so a plain decode
  always_comb begin
    imm_wr_ch = '0;
    trig_wr_ch = '0;
    offset_wr_ch = '0;
    gain_wr_ch = '0;
    imm_wr_ch[ch] = imm_wr;
    trig_wr_ch[ch] = trig_wr;
    offset_wr_ch[ch] = offset_wr;
    gain_wr_ch[ch] = gain_wr;
  end

  // Channels copied at a trigger: only those waiting for it
  assign copy_ch = trigger_event ? pending_reg : '0;

  // Relay programming; write is taken at once, relays move later
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      relay_reg <= RELAY_RESET;
    end else if (relay_wr) begin
      relay_reg <= req.wdata;
    end
  end

  // Mechanical settle time, shown as a busy level only
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      settle_reg <= '0;
    end else if (relay_wr) begin
      settle_reg <= SETTLE_CNT_W'(RELAY_SETTLE);
    end else if (settle_reg != '0) begin
      settle_reg <= settle_reg - SETTLE_CNT_W'(1);
    end
  end

  // Card control page select
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      page_reg <= PAGE_RESET;
    end else if (card_wr) begin
      page_reg <= req.wdata[PAGE_LSB +: PAGE_W];
    end
  end

  // Program enable; starts off so no stray write reaches the store
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      prog_en_reg <= PROG_EN_RESET;
    end else if (card_wr) begin
      prog_en_reg <= req.wdata[PROG_EN_BIT];
    end
  end

  // Main codes: immediate write wins over a trigger copy on its channel
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      main_reg <= {NUM_CH{MAIN_RESET}};
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (imm_wr_ch[i]) begin
          main_reg[i] <= req.wdata;
        end else if (copy_ch[i]) begin
          main_reg[i] <= hold_reg[i];
        end
      end
    end
  end

  // Holding registers keep a triggered value until the trigger
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      hold_reg <= {NUM_CH{MAIN_RESET}};
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (trig_wr_ch[i]) begin
          hold_reg[i] <= req.wdata;
        end
      end
    end
  end

  // Pending flags; a new triggered write beats the trigger's clear
  always_comb begin
    pending_next = pending_reg;
    if (trigger_event) begin
      pending_next = '0;
    end
    if (imm_wr) begin
      pending_next[ch] = 1'b0;
    end
    if (trig_wr) begin
      pending_next[ch] = 1'b1;
    end
  end

  // Pending flag register
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pending_reg <= '0;
    end else begin
      pending_reg <= pending_next;
    end
  end

  // Offset trims, applied as soon as written; upper nibble ignored
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      offset_reg <= {NUM_CH{TRIM_RESET}};
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (offset_wr_ch[i]) begin
          offset_reg[i] <= req.wdata[11:0];
        end
      end
    end
  end

  // Gain trims, same handling as the offsets
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      gain_reg <= {NUM_CH{TRIM_RESET}};
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (gain_wr_ch[i]) begin
          gain_reg[i] <= req.wdata[11:0];
        end
      end
    end
  end

  // Calibration store; contents survive reset, as flash would
  always_ff @(posedge ref_clk) begin
    if (nv_wr && !rst) begin
      nv_mem[eff_addr[7:1]] <= req.wdata;
    end
  end

  // Relay readback; an eight-channel build has no upper relays
  always_comb begin
    relay_rd_value = relay_reg;
    if (eight_sync_reg[1]) begin
      relay_rd_value = relay_reg | UPPER_CH_ONES;
    end
  end

  // Card control readback; unused bits read zero
  always_comb begin
    card_rd_value = 16'h0000;
    card_rd_value[PAGE_LSB +: PAGE_W] = page_reg;
    card_rd_value[PROG_EN_BIT] = prog_en_reg;
  end

  // Read mux; converter registers are write-only and read zero
  always_comb begin
    rd_next = 16'h0000;
    if (relay_sel) begin
      rd_next = relay_rd_value;
    end else if (card_sel) begin
      rd_next = card_rd_value;
    end else if (nv_hit) begin
      rd_next = nv_mem[eff_addr[7:1]];
    end
  end

  // Read valid: one-cycle pulse after the strobe
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= req.rd;
    end
  end

  // Read data holds until the next read
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rd_data <= 16'h0000;
    end else if (req.rd) begin
      rd_data <= rd_next;
    end
  end

  // Relay and status outputs straight from their registers
  assign channel_output_switch = relay_reg;
  assign relay_busy = (settle_reg != '0);
  assign trigger_pending = pending_reg;
  assign nv_program_voltage_enable = prog_en_reg;

  // Converter codes leave straight from their registers
  assign dac_codes = '{
    main_code: main_reg,
    offset_code: offset_reg,
    gain_code: gain_reg
  };
endmodule : dac_module_register_bank

// file: verification/dac_bank_props.sv
// Checker for the register bank ports
`timescale 1ns/1ps
module dac_bank_props (
  input wire logic ref_clk, // Clock
  input wire logic rst, // Reset
  input wire dac_regs_pkg::reg_req_t req, // Request
  input wire logic rd_valid, // Read valid
  input wire logic trigger_event, // Trigger
  input wire logic [15:0] channel_output_switch, // Relays
  input wire logic relay_busy, // Settling
  input wire logic [15:0] trigger_pending, // Pending
  input wire logic nv_program_voltage_enable, // Prog voltage
  input wire dac_regs_pkg::dac_codes_t dac_codes // Codes
);
  import dac_regs_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Wide-space write decodes
  wire rw = req.wr && req.wide && req.addr == RELAY_CTRL_OFS;
  wire cw = req.wr && req.wide && req.addr == CARD_CTRL_OFS;
  wire tw = req.wr && req.wide && req.addr[8:5] == GRP_TRIG;
  wire iw = req.wr && req.wide && req.addr[8:5] == GRP_IMM;
  wire ow = req.wr && req.wide && req.addr[8:5] == GRP_OFFSET;
  a_read_answer: assert property (req.rd |=> rd_valid) else $error("read unanswered");
  a_relay_value: assert property (rw |=> channel_output_switch == $past(req.wdata)) else $error("relay");
  a_relay_settle: assert property (rw |=> relay_busy) else $error("no settle");
  a_pend_set: assert property (tw |=> trigger_pending[$past(req.addr[4:1])]) else $error("pend");
  a_imm_apply: assert property (iw |=> dac_codes.main_code[$past(req.addr[4:1])] == $past(req.wdata)
    && !trigger_pending[$past(req.addr[4:1])]) else $error("imm");
  a_trig_clear: assert property (trigger_event && !req.wr |=> trigger_pending == 16'h0000) else $error("trig");
  a_main_hold: assert property (!trigger_event && !req.wr |=> $stable(dac_codes.main_code)) else $error("hold");
  a_prog_en: assert property (cw |=> nv_program_voltage_enable == $past(req.wdata[4])) else $error("vpp");
  a_trim_apply: assert property (ow |=> dac_codes.offset_code[$past(req.addr[4:1])] == $past(req.wdata[11:0]))
    else $error("trim");
endmodule : dac_bank_props
bind dac_module_register_bank dac_bank_props i_props (.ref_clk(ref_clk), .rst(rst), .req(req),
  .rd_valid(rd_valid), .trigger_event(trigger_event), .channel_output_switch(channel_output_switch),
  .relay_busy(relay_busy), .trigger_pending(trigger_pending),
  .nv_program_voltage_enable(nv_program_voltage_enable), .dac_codes(dac_codes));

// file: verification/bus_ctrl_model.sv
// Backplane controller model issuing register accesses
`timescale 1ns/1ps
module bus_ctrl_model (
  input wire logic ref_clk, // Clock
  output dac_regs_pkg::reg_req_t req, // Request
  input wire logic [15:0] rd_data, // Read data
  input wire logic rd_valid // Read valid
);
  import dac_regs_pkg::*;
  initial req = '0;
  // Released lines flip so a stale value never looks valid
  task automatic drop();
    req.wr = 1'b0;
    req.rd = 1'b0;
    req.addr = ~req.addr;
    req.wdata = ~req.wdata;
  endtask : drop
  task automatic wr(input logic wide, input logic [8:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    #1 req = '{wr: 1'b1, rd: 1'b0, wide: wide, addr: a, wdata: d};
    @(posedge ref_clk);
    #1 drop();
  endtask : wr
  // Strobe lasts one cycle; answer awaited under a bound
  task automatic rd(input logic wide, input logic [8:0] a, output logic [15:0] d, output bit ok);
    ok = 1'b0;
    d = '0;
    @(posedge ref_clk);
    #1 req = '{wr: 1'b0, rd: 1'b1, wide: wide, addr: a, wdata: req.wdata};
    @(posedge ref_clk);
    #1 drop();
    for (int i = 0; i < 4 && !ok; i++) begin
      if (rd_valid === 1'b1) begin
        ok = 1'b1;
        d = rd_data;
      end else begin
        @(posedge ref_clk);
        #1;
      end
    end
  endtask : rd
endmodule : bus_ctrl_model

// file: verification/dac_module_register_bank_test.sv
// Testbench for the register bank
`timescale 1ns/1ps
module dac_module_register_bank_test;
  import dac_regs_pkg::*;
  localparam int SET = 20;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic trigger_event = 1'b0;
  logic eight_channel_pin = 1'b0;
  logic cal_jumper_pin = 1'b0;
  reg_req_t req;
  logic [15:0] rd_data, channel_output_switch, trigger_pending;
  logic rd_valid, relay_busy, nv_program_voltage_enable;
  dac_codes_t dac_codes;
  int n_fail = 0;
  int num_checks = 0;
  always #2 ref_clk = ~ref_clk;
  bus_ctrl_model i_ctrl (.ref_clk(ref_clk), .req(req), .rd_data(rd_data), .rd_valid(rd_valid));
  dac_module_register_bank #(.RELAY_SETTLE(SET)) i_dut (.ref_clk(ref_clk), .rst(rst), .req(req),
    .rd_data(rd_data), .rd_valid(rd_valid), .trigger_event(trigger_event),
    .eight_channel_pin(eight_channel_pin), .cal_jumper_pin(cal_jumper_pin),
    .channel_output_switch(channel_output_switch), .relay_busy(relay_busy),
    .trigger_pending(trigger_pending), .nv_program_voltage_enable(nv_program_voltage_enable),
    .dac_codes(dac_codes));
  task automatic complete_run();
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : complete_run
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic rchk(input logic wide, input logic [8:0] a, input logic [15:0] exp);
    logic [15:0] d;
    bit ok;
    i_ctrl.rd(wide, a, d, ok);
    if (!ok) begin
      n_fail++;
      $display("[ERR] rd_valid expected 1 seen 0");
      complete_run();
    end else chk($sformatf("read %h", a), exp, d);
  endtask : rchk
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : step
  task automatic pulse_trig();
    step(1);
    trigger_event = 1'b1;
    step(1);
    trigger_event = 1'b0;
  endtask : pulse_trig
  // Main sequence
  initial begin
    int i;
    repeat (8) @(posedge ref_clk);
    #1 rst = 1'b0;
    rchk(1, RELAY_CTRL_OFS, 16'hFFFF);
    rchk(1, CARD_CTRL_OFS, 16'h0000);
    chk("trim", 16'h0800, {4'h0, dac_codes.offset_code[7]});
    i_ctrl.wr(1, RELAY_CTRL_OFS, 16'h00A5);
    chk("switch", 16'h00A5, channel_output_switch);
    chk("busy", 16'h0001, 16'(relay_busy));
    for (i = 0; i < SET + 5 && relay_busy === 1'b1; i++) step(1);
    chk("settle", 16'h0001, 16'(i >= SET - 3 && i <= SET + 1));
    eight_channel_pin = 1'b1;
    step(4);
    rchk(1, RELAY_CTRL_OFS, 16'hFFA5);
    eight_channel_pin = 1'b0;
    step(4);
    rchk(1, RELAY_CTRL_OFS, 16'h00A5);
    i_ctrl.wr(1, 9'h0C0, 16'hBEEF);
    rchk(1, 9'h0C0, 16'h0000);
    rchk(1, IMM_VALUE_OFS, 16'h0000);
    // Pages 2 to 5 each reach their own group through the narrow window
    for (int p = 2; p < 6; p++) begin
      i_ctrl.wr(1, CARD_CTRL_OFS, 16'(p));
      i_ctrl.wr(0, 9'(WINDOW_LO_OFS + 2 * p), 16'(p * 16'h1111));
    end
    rchk(0, CARD_CTRL_OFS, 16'h0005);
    chk("main", 16'h2222, dac_codes.main_code[2]);
    chk("ofs", 16'h0444, {4'h0, dac_codes.offset_code[4]});
    chk("gain", 16'h0555, {4'h0, dac_codes.gain_code[5]});
    i_ctrl.wr(1, TRIG_VALUE_OFS, 16'h1234);
    i_ctrl.wr(1, 9'h07E, 16'h8000);
    chk("held", 16'h0000, dac_codes.main_code[0]);
    chk("pend", 16'h8009, trigger_pending);
    pulse_trig();
    chk("m1", 16'h1234, dac_codes.main_code[0]);
    chk("m16", 16'h8000, dac_codes.main_code[15]);
    chk("m4", 16'h3333, dac_codes.main_code[3]);
    chk("pend", 16'h0000, trigger_pending);
    i_ctrl.wr(1, TRIG_VALUE_OFS, 16'h7777);
    i_ctrl.wr(1, IMM_VALUE_OFS, 16'h0FFF);
    chk("pend", 16'h0000, trigger_pending);
    pulse_trig();
    chk("m1", 16'h0FFF, dac_codes.main_code[0]);
    // Nonvolatile writes need enable and jumper both
    i_ctrl.wr(1, CARD_CTRL_OFS, 16'h0010);
    chk("vpp", 16'h0001, 16'(nv_program_voltage_enable));
    cal_jumper_pin = 1'b1;
    step(4);
    i_ctrl.wr(1, NV_BASE_OFS, 16'h5A5A);
    rchk(1, NV_BASE_OFS, 16'h5A5A);
    i_ctrl.wr(1, CARD_CTRL_OFS, 16'h0000);
    i_ctrl.wr(1, NV_BASE_OFS, 16'h1111);
    i_ctrl.wr(1, CARD_CTRL_OFS, 16'h0018);
    cal_jumper_pin = 1'b0;
    step(4);
    i_ctrl.wr(1, NV_BASE_OFS, 16'h2222);
    rchk(0, WINDOW_LO_OFS, 16'h5A5A);
    // Reset in mid-run: state returns, calibration store survives
    step(1);
    rst = 1'b1;
    step(2);
    rst = 1'b0;
    rchk(1, RELAY_CTRL_OFS, 16'hFFFF);
    chk("gain", 16'h0800, {4'h0, dac_codes.gain_code[5]});
    chk("m1", 16'h0000, dac_codes.main_code[0]);
    rchk(1, NV_BASE_OFS, 16'h5A5A);
    complete_run();
  end
  // Watchdog against a hang
  initial begin
    #100000;
    n_fail++;
    $display("[ERR] run expected done seen hang");
    complete_run();
  end
endmodule : dac_module_register_bank_test
